// file: hdl/mdt_pkg.sv
// Constants for the multimode down timer channel
package mdt_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [4:0] OFF_MODE   = 5'h00;
  localparam logic [4:0] OFF_CTRL   = 5'h04;
  localparam logic [4:0] OFF_TIMER  = 5'h08;
  localparam logic [4:0] OFF_MEAS   = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_MASK   = 5'h14;
  localparam logic [4:0] OFF_PORT   = 5'h18;

  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int MODE_LSB   = 0;
  localparam int CSEL_LSB   = 2;
  localparam int GATE_EN    = 4;
  localparam int GATE_LVL   = 5;
  localparam int PULSE_EN   = 6;
  localparam int EDGE_FALL  = 7;
  localparam int EVT_OVF    = 8;
  localparam int WIDTH_SEL  = 9;
  localparam int PWM_EN     = 10;
  localparam int MODE_REG_W = 11;

  localparam logic [1:0] M_TIMER   = 2'h0;
  localparam logic [1:0] M_EVENT   = 2'h1;
  localparam logic [1:0] M_ONESHOT = 2'h2;
  localparam logic [1:0] M_MEASURE = 2'h3;

  localparam logic [1:0] CS_DIV1   = 2'h0;
  localparam logic [1:0] CS_DIV8   = 2'h1;
  localparam logic [1:0] CS_DIV32  = 2'h2;
  localparam logic [1:0] CS_SUB32  = 2'h3;

  // ****************************************************************
  // Status, port fields and reset values
  // ****************************************************************
  localparam int ST_UF      = 0;
  localparam int ST_MEAS    = 1;
  localparam int ST_MOVF    = 2;
  localparam int ST_W       = 3;
  localparam int PORT_DIR   = 0;
  localparam int PORT_OUT   = 1;
  localparam int PORT_IN    = 2;

  localparam logic [MODE_REG_W-1:0] MODE_RST = 11'h000;
  localparam logic [CNT_W-1:0]      CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]      CNT_MAX  = 16'hFFFF;
  localparam logic [ST_W-1:0]       ST_RST   = 3'h0;

  // ****************************************************************
  // Prescaler counts and AXI response codes
  // ****************************************************************
  localparam int DIV8  = 8;
  localparam int DIV32 = 32;
  localparam logic [4:0] PRE_LAST8  = 5'(DIV8 - 1);
  localparam logic [4:0] PRE_LAST32 = 5'(DIV32 - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mdt_pkg

// file: hdl/mdt_top.sv
// Multimode down timer channel with AXI4-Lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns

module mdt_top (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic [mdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [mdt_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [mdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [mdt_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       subclk_in,
  input  wire logic                       timer_ovf_in,
  input  wire logic                       channel_io_pin_in,
  output logic                            channel_io_pin_out,
  output logic                            channel_io_pin_oe_n,
  output logic                            irq
);
  localparam int W = mdt_pkg::CNT_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [mdt_pkg::MODE_REG_W-1:0] mode_reg;
  logic                           start_reg;
  logic [W-1:0]                   reload_reg;
  logic [W-1:0]                   cnt_reg;
  logic [W-1:0]                   meas_reg;
  logic [mdt_pkg::ST_W-1:0]       status_reg;
  logic [mdt_pkg::ST_W-1:0]       mask_reg;
  logic [mdt_pkg::ST_W-1:0]       st_set;
  logic                           gpio_dir_reg;
  logic                           gpio_out_reg;
  logic [mdt_pkg::ADDR_W-1:0]     waddr_reg;
  logic [31:0]                    wdata_reg;
  logic [3:0]                     wstrb_reg;
  logic                           wr_en;
  logic [31:0]                    rd_mux;
  logic                           rd_hit;
  logic                           wr_hit;
  logic [2:0]                     pin_sync_reg;
  logic [2:0]                     sub_sync_reg;
  logic [4:0]                     pre_reg;
  logic [4:0]                     sub_pre_reg;
  logic                           pin_lvl;
  logic                           pin_rise;
  logic                           pin_fall;
  logic                           src_tick;
  logic                           tick;
  logic                           run;
  logic                           meas_edge;
  logic                           uf;
  logic                           os_done;
  logic                           wr_timer;
  logic                           wr_ctrl;
  logic                           os_load;
  logic [1:0]                     mode;
  logic                           pwm_mode;
  logic                           pulse_mode;
  logic                           port_mode;

  assign mode       = mode_reg[mdt_pkg::MODE_LSB +: 2];
  assign pwm_mode   = (mode == mdt_pkg::M_MEASURE) &&
                      mode_reg[mdt_pkg::PWM_EN];
  assign pulse_mode = (mode == mdt_pkg::M_TIMER) &&
                      mode_reg[mdt_pkg::PULSE_EN];
  assign port_mode  = (mode == mdt_pkg::M_TIMER) &&
                      !mode_reg[mdt_pkg::PULSE_EN] &&
                      !mode_reg[mdt_pkg::GATE_EN];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Ready drops after each take so address and data may come in
  // either order; the response reopens both.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mdt_pkg::RESP_OKAY;
      waddr_reg     <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        waddr_reg     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? mdt_pkg::RESP_OKAY
                                : mdt_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_en    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_timer = wr_en && (waddr_reg == mdt_pkg::OFF_TIMER);
  assign wr_ctrl  = wr_en && (waddr_reg == mdt_pkg::OFF_CTRL);
  assign os_load  = wr_ctrl && wdata_reg[0] && !start_reg &&
                    (mode == mdt_pkg::M_ONESHOT);

  always_comb begin
    unique case (waddr_reg)
      mdt_pkg::OFF_MODE, mdt_pkg::OFF_CTRL, mdt_pkg::OFF_TIMER,
      mdt_pkg::OFF_MEAS, mdt_pkg::OFF_STATUS, mdt_pkg::OFF_MASK,
      mdt_pkg::OFF_PORT: wr_hit = 1'b1;
      default:           wr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      mdt_pkg::OFF_MODE:   rd_mux = 32'(mode_reg);
      mdt_pkg::OFF_CTRL:   rd_mux = 32'(start_reg);
      mdt_pkg::OFF_TIMER:  rd_mux = 32'(cnt_reg);
      mdt_pkg::OFF_MEAS:   rd_mux = 32'(meas_reg);
      mdt_pkg::OFF_STATUS: rd_mux = 32'(status_reg);
      mdt_pkg::OFF_MASK:   rd_mux = 32'(mask_reg);
      mdt_pkg::OFF_PORT:   rd_mux = 32'({pin_lvl, gpio_out_reg,
                                          gpio_dir_reg});
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mdt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? mdt_pkg::RESP_OKAY
                              : mdt_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg     <= mdt_pkg::MODE_RST;
      mask_reg     <= mdt_pkg::ST_RST;
      gpio_dir_reg <= 1'b0;
      gpio_out_reg <= 1'b0;
    end else if (wr_en) begin
      if (waddr_reg == mdt_pkg::OFF_MODE) begin
        mode_reg <= mdt_pkg::MODE_REG_W'(merge(32'(mode_reg),
                                              wdata_reg, wstrb_reg));
      end
      if (waddr_reg == mdt_pkg::OFF_MASK && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[mdt_pkg::ST_W-1:0];
      end
      if (waddr_reg == mdt_pkg::OFF_PORT && wstrb_reg[0]) begin
        gpio_dir_reg <= wdata_reg[mdt_pkg::PORT_DIR];
        gpio_out_reg <= wdata_reg[mdt_pkg::PORT_OUT];
      end
    end
  end

  // Software set wins over the one-shot's own stop in one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      start_reg <= 1'b0;
    end else if (wr_ctrl && wstrb_reg[0]) begin
      start_reg <= wdata_reg[0];
    end else if (os_done) begin
      start_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reload_reg <= mdt_pkg::CNT_RST;
    end else if (wr_timer) begin
      reload_reg <= W'(merge(32'(reload_reg), wdata_reg,
                             wstrb_reg));
    end
  end

  // ****************************************************************
  // Input synchronisers and prescaler
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_sync_reg <= 3'h0;
      sub_sync_reg <= 3'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], channel_io_pin_in};
      sub_sync_reg <= {sub_sync_reg[1:0], subclk_in};
    end
  end

  assign pin_lvl  = pin_sync_reg[1];
  assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
  assign pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];

  // Sub clock must be well below ref_clk/2 to be seen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_reg     <= 5'h00;
      sub_pre_reg <= 5'h00;
    end else begin
      pre_reg <= pre_reg + 5'h01;
      if (sub_sync_reg[1] && !sub_sync_reg[2]) begin
        sub_pre_reg <= sub_pre_reg + 5'h01;
      end
    end
  end

  always_comb begin
    unique case (mode_reg[mdt_pkg::CSEL_LSB +: 2])
      mdt_pkg::CS_DIV1:  src_tick = 1'b1;
      mdt_pkg::CS_DIV8:  src_tick = pre_reg[2:0] ==
                                    mdt_pkg::PRE_LAST8[2:0];
      mdt_pkg::CS_DIV32: src_tick = pre_reg == mdt_pkg::PRE_LAST32;
      default:           src_tick = sub_pre_reg ==
                                    mdt_pkg::PRE_LAST32 &&
                                    sub_sync_reg[1] &&
                                    !sub_sync_reg[2];
    endcase
  end

  // ****************************************************************
  // Tick and run qualification
  // ****************************************************************
  always_comb begin
    if (mode == mdt_pkg::M_EVENT) begin
      if (mode_reg[mdt_pkg::EVT_OVF]) begin
        tick = timer_ovf_in;
      end else begin
        tick = mode_reg[mdt_pkg::EDGE_FALL] ? pin_fall
                                            : pin_rise;
      end
    end else begin
      tick = src_tick;
    end
  end

  assign run = start_reg &&
               !(mode == mdt_pkg::M_TIMER &&
                 mode_reg[mdt_pkg::GATE_EN] &&
                 pin_lvl != mode_reg[mdt_pkg::GATE_LVL]);

  // Period uses one edge, width uses both
  assign meas_edge = mode_reg[mdt_pkg::WIDTH_SEL] ?
                     (pin_rise || pin_fall) :
                     (mode_reg[mdt_pkg::EDGE_FALL] ? pin_fall
                                                   : pin_rise);

  assign uf = run && tick && cnt_reg == mdt_pkg::CNT_RST &&
              (mode == mdt_pkg::M_TIMER ||
               mode == mdt_pkg::M_EVENT || pwm_mode);
  assign os_done = run && tick && cnt_reg == mdt_pkg::CNT_RST &&
                   mode == mdt_pkg::M_ONESHOT;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg  <= mdt_pkg::CNT_RST;
      meas_reg <= mdt_pkg::CNT_RST;
    end else if (wr_timer && !start_reg) begin
      cnt_reg <= W'(merge(32'(reload_reg), wdata_reg,
                          wstrb_reg));
    end else if (os_load) begin
      cnt_reg <= reload_reg;
    end else if (run && mode == mdt_pkg::M_MEASURE && !pwm_mode) begin
      if (meas_edge) begin
        meas_reg <= cnt_reg;
        cnt_reg  <= mdt_pkg::CNT_RST;
      end else if (tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end else if (run && tick) begin
      if (cnt_reg == mdt_pkg::CNT_RST) begin
        if (mode != mdt_pkg::M_ONESHOT) begin
          cnt_reg <= reload_reg;
        end
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  assign st_set[mdt_pkg::ST_UF]   = uf || os_done;
  assign st_set[mdt_pkg::ST_MEAS] = run && meas_edge && !pwm_mode &&
                                    mode == mdt_pkg::M_MEASURE;
  assign st_set[mdt_pkg::ST_MOVF] = run && tick && !meas_edge &&
                                    !pwm_mode &&
                                    mode == mdt_pkg::M_MEASURE &&
                                    cnt_reg == mdt_pkg::CNT_MAX;

  // Set beats a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= mdt_pkg::ST_RST;
    end else if (wr_en && waddr_reg == mdt_pkg::OFF_STATUS &&
                 wstrb_reg[0]) begin
      status_reg <= (status_reg & ~wdata_reg[mdt_pkg::ST_W-1:0]) |
                    st_set;
    end else begin
      status_reg <= status_reg | st_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ****************************************************************
  // Timer pin
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      channel_io_pin_out  <= 1'b0;
      channel_io_pin_oe_n <= 1'b1;
    end else begin
      if (pwm_mode) begin
        channel_io_pin_out <= cnt_reg < reload_reg;
      end else if (pulse_mode) begin
        if (uf) begin
          channel_io_pin_out <= !channel_io_pin_out;
        end
      end else begin
        channel_io_pin_out <= gpio_out_reg;
      end
      // Input functions release the pin
      channel_io_pin_oe_n <= !(pwm_mode || pulse_mode ||
                               (port_mode && gpio_dir_reg));
    end
  end
endmodule // mdt_top

// file: verif/mdt_pin_model.sv
// Far-side model of the timer pin: level source and load
`timescale 1ns/1ns
module mdt_pin_model (
  input  wire logic ref_clk,
  input  wire logic channel_io_pin_out,
  input  wire logic channel_io_pin_oe_n,
  input  wire logic src_level,
  output logic      pin_level,
  output int        toggles,
  output longint    last_gap
);
  logic   prev;
  longint last_t;
  // Source only drives while the device lets go of the pin
  assign pin_level = channel_io_pin_oe_n ? src_level : channel_io_pin_out;
  initial begin
    toggles = 0;
    last_gap = 0;
    last_t = 0;
    prev = 1'b0;
  end
  // Clock-sampled so gaps come out in whole cycles
  always @(posedge ref_clk) begin
    if (!channel_io_pin_oe_n && pin_level !== prev) begin
      toggles <= toggles + 1;
      last_gap <= $time - last_t;
      last_t <= $time;
    end
    prev <= pin_level;
  end
endmodule // mdt_pin_model

// file: verif/mdt_top_props.sv
// Port-level assertions for the timer channel
`timescale 1ns/1ns
module mdt_top_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        channel_io_pin_oe_n,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rst_idle;
    disable iff (1'b0) reset |=> !irq && channel_io_pin_oe_n && !s_axi_bvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset idle");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing");
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write not blocked");
  property p_rd_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("read not blocked");
  // Sticky request only goes away through a register write
  property p_irq_clr;
    $fell(irq) |-> $past(s_axi_bvalid);
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq fell alone");
endmodule // mdt_top_props

bind mdt_top mdt_top_props mdt_top_props_i (.ref_clk(ref_clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel_io_pin_oe_n(channel_io_pin_oe_n), .irq(irq));

// file: verif/testbench.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ns
module testbench;
  logic        ref_clk, reset, subclk_in, timer_ovf_in, src_level, pin_level;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, n, c1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, channel_io_pin_out;
  logic        channel_io_pin_oe_n, irq;
  int          errors, samples_checked, toggles;
  longint      last_gap, per;
  logic [33:0] exp_q[$];

  mdt_top mdt_top_i (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .subclk_in, .timer_ovf_in, .channel_io_pin_in(pin_level),
    .channel_io_pin_out, .channel_io_pin_oe_n, .irq);
  mdt_pin_model mdt_pin_model_i (.ref_clk, .channel_io_pin_out,
    .channel_io_pin_oe_n, .src_level, .pin_level, .toggles, .last_gap);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check({32'h0, s_axi_bresp}, {32'h0, r});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] e = 34'h0,
                    input bit chk = 1'b1);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    if (chk) exp_q.push_back(e);
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_val = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_tog(input int k);
    int t0;
    t0 = toggles;
    wait (toggles >= t0 + k);
  endtask

  always @(posedge ref_clk)
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    subclk_in = 1'b0;
    forever #35 subclk_in = ~subclk_in;
  end
  initial begin
    #1000000;
    errors++;
    summarize();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, timer_ovf_in, src_level, errors, samples_checked} = '0;
    s_axi_wstrb = 4'hF;
    reset = 1'b1;
    void'($urandom(32'h456cdc80));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    // Unmapped word at 0x1C answers with an error
    for (int a = 0; a < 32; a += 4) rd(5'(a), {2'(a == 28) << 1, 32'h0});
    wr(5'h1C, 32'h1, 2'h2);
    for (int m = 0; m < 4; m++) begin
      n = ($urandom & 32'h7FC) | 32'(m);
      wr(mdt_pkg::OFF_MODE, n);
      rd(mdt_pkg::OFF_MODE, {2'h0, n});
    end
    $display("test reset and mode done");
    wr(mdt_pkg::OFF_MASK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      n = 2 + $urandom % 6;
      wr(mdt_pkg::OFF_CTRL, 32'h0);
      wr(mdt_pkg::OFF_MODE, (32'h1 << mdt_pkg::PULSE_EN) | 32'(c << 2));
      wr(mdt_pkg::OFF_TIMER, n);
      rd(mdt_pkg::OFF_TIMER, {2'h0, n});
      wr(mdt_pkg::OFF_CTRL, 32'h1);
      wait_tog(3);
      per = longint'(n + 1) * (c == 0 ? 1 : c == 1 ? 8 : 32) * (c == 3 ? 70 : 20);
      // Sub clock is resynchronised, so allow two cycles of jitter
      check(34'(last_gap >= per - (c == 3) * 40 && last_gap <= per + (c == 3) * 40), 34'h1);
      check(34'(channel_io_pin_oe_n), 34'h0);
    end
    wr(mdt_pkg::OFF_CTRL, 32'h0);
    check(34'(irq), 34'h1);
    wr(mdt_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    check(34'(irq), 34'h0);
    wr(mdt_pkg::OFF_MASK, 32'h1);
    wr(mdt_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    check(34'(irq), 34'h0);
    $display("test periods and irq done");
    wr(mdt_pkg::OFF_MODE, 32'h1 << mdt_pkg::PULSE_EN);
    wr(mdt_pkg::OFF_TIMER, 32'd20);
    wr(mdt_pkg::OFF_CTRL, 32'h1);
    wait_tog(2);
    n = 3 + $urandom % 5;
    wr(mdt_pkg::OFF_TIMER, n);
    wait_tog(1);
    check(34'(last_gap), 34'd420);
    wait_tog(1);
    check(34'(last_gap), 34'((n + 1) * 20));
    wr(mdt_pkg::OFF_CTRL, 32'h0);
    rd(mdt_pkg::OFF_TIMER, 34'h0, 1'b0);
    c1 = rd_val;
    repeat (30) @(posedge ref_clk);
    rd(mdt_pkg::OFF_TIMER, {2'h0, c1});
    $display("test reload and hold done");
    wr(mdt_pkg::OFF_MODE, 32'h3 << mdt_pkg::GATE_EN);
    wr(mdt_pkg::OFF_TIMER, 32'd100);
    wr(mdt_pkg::OFF_CTRL, 32'h1);
    repeat (10) @(posedge ref_clk);
    rd(mdt_pkg::OFF_TIMER, {2'h0, 32'd100});
    src_level <= 1'b1;
    repeat (30) @(posedge ref_clk);
    src_level <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(mdt_pkg::OFF_TIMER, 34'h0, 1'b0);
    c1 = rd_val;
    check(34'(c1 > 60 && c1 < 90), 34'h1);
    rd(mdt_pkg::OFF_TIMER, {2'h0, c1});
    wr(mdt_pkg::OFF_CTRL, 32'h0);
    wr(mdt_pkg::OFF_MODE, 32'(mdt_pkg::M_ONESHOT));
    wr(mdt_pkg::OFF_TIMER, 32'd10);
    wr(mdt_pkg::OFF_STATUS, 32'h7);
    wr(mdt_pkg::OFF_CTRL, 32'h1);
    repeat (30) @(posedge ref_clk);
    rd(mdt_pkg::OFF_TIMER, 34'h0);
    rd(mdt_pkg::OFF_CTRL, 34'h0);
    rd(mdt_pkg::OFF_STATUS, 34'h1);
    $display("test gate and one-shot done");
    wr(mdt_pkg::OFF_MODE, (32'h1 << mdt_pkg::PWM_EN) | 32'h3);
    wr(mdt_pkg::OFF_TIMER, n);
    wr(mdt_pkg::OFF_CTRL, 32'h1);
    wait_tog(2);
    per = last_gap;
    wait_tog(1);
    check(34'(per + last_gap), 34'((n + 1) * 20));
    check(34'(per * last_gap), 34'(n * 400));
    wr(mdt_pkg::OFF_MODE, 32'h3);
    repeat (6) begin
      src_level <= !src_level;
      repeat (n) @(posedge ref_clk);
    end
    rd(mdt_pkg::OFF_MEAS, {2'h0, 2 * n - 1});
    for (int s = 0; s < 2; s++) begin
      n = 1 + $urandom % 5;
      wr(mdt_pkg::OFF_CTRL, 32'h0);
      wr(mdt_pkg::OFF_MODE, 32'(s << mdt_pkg::EVT_OVF) | 32'h1);
      wr(mdt_pkg::OFF_TIMER, 32'd10);
      wr(mdt_pkg::OFF_CTRL, 32'h1);
      repeat (n) begin
        repeat (4) @(posedge ref_clk);
        if (s == 1) timer_ovf_in <= 1'b1;
        else src_level <= 1'b1;
        @(posedge ref_clk);
        timer_ovf_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        src_level <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      rd(mdt_pkg::OFF_TIMER, {2'h0, 32'd10 - n});
    end
    $display("test event done");
    summarize();
  end
endmodule // testbench
